/* i2cpc_port_config.sv */
// Port configuration register with two-wire glitch filter, data-line slope
// control and sample-ready routing to the first audio output pin.
// Assumes an APB master on pclk; scl/sda pins are asynchronous to pclk,
// sample_ready and audio_data come from logic on pclk.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps

module i2cpc_port_config #(
	parameter bit SPI_VARIANT = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             scl_filt,
	output logic             sda_filt,
	output logic             filter_active,
	input  wire logic        target_sda_low,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             sda_slow_fall,
	input  wire logic        sample_ready,
	input  wire logic        audio_data,
	output logic             audio_out_pin0
);

	// ****************************************************************
	// Register bus
	// ****************************************************************
	logic [7:0]  cfg;
	logic [7:0]  next_cfg;
	logic [31:0] next_prdata;
	logic        hit;
	logic        setup;
	logic        access;

	assign hit    = (paddr == i2cpc_pkg::ADDR_CFG);
	assign setup  = psel && !penable;
	assign access = psel && penable;
	// Zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = access && !hit;

	// Read data is fetched in setup so it leaves a flop in the access cycle
	always_comb begin
		next_cfg    = cfg;
		next_prdata = prdata;
		if (access && pwrite && hit) begin
			next_cfg = pwdata[7:0] & i2cpc_pkg::CFG_WMASK;
		end
		if (setup) begin
			next_prdata = hit ? {24'h00_0000, cfg & i2cpc_pkg::CFG_WMASK} : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg    <= i2cpc_pkg::CFG_RESET;
			prdata <= 32'h0000_0000;
		end else begin
			cfg    <= next_cfg;
			prdata <= next_prdata;
		end
	end

	// ****************************************************************
	// Glitch filter
	// ****************************************************************
	logic       bypass;
	logic       high_speed;
	logic [1:0] need;
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] filt;
	logic [1:0] next_filt;
	logic [1:0] cnt [2];
	logic [1:0] next_cnt [2];

	// Four-wire builds have no two-wire target, so the filter is simply off
	assign bypass        = cfg[i2cpc_pkg::BIT_BYPASS] || SPI_VARIANT;
	assign filter_active = !bypass;
	assign high_speed    = cfg[i2cpc_pkg::BIT_HIGH_SPEED];
	// One cycle of 40 ns covers the 10 ns width; two cover 50 ns
	assign need = high_speed ? i2cpc_pkg::FILT_HS_CYC : i2cpc_pkg::FILT_STD_CYC;

	// Unless bypassed, a line changes only after the new level holds for the rejection width
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_filt[i] = filt[i];
			next_cnt[i]  = 2'b00;
			if (bypass) begin
				next_filt[i] = sync2[i];
			end else if (sync2[i] != filt[i]) begin
				if (2'(cnt[i] + 2'b01) >= need) begin
					next_filt[i] = sync2[i];
				end else begin
					next_cnt[i] = 2'(cnt[i] + 2'b01);
				end
			end
		end
	end

	// Synchroniser idles high like an idle two-wire bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1  <= 2'b11;
			sync2  <= 2'b11;
			filt   <= 2'b11;
			cnt[0] <= 2'b00;
			cnt[1] <= 2'b00;
		end else begin
			sync1  <= {sda_in, scl_in};
			sync2  <= sync1;
			filt   <= next_filt;
			cnt[0] <= next_cnt[0];
			cnt[1] <= next_cnt[1];
		end
	end

	assign scl_filt = filt[0];
	assign sda_filt = filt[1];

	// ****************************************************************
	// Data-line driver and audio pin
	// ****************************************************************
	logic next_sda_oe;
	logic next_pin0;

	// Open drain: only ever pulls low; slope control goes to the pad
	always_comb begin
		next_sda_oe = target_sda_low;
		next_pin0   = cfg[i2cpc_pkg::BIT_ROUTE] ? sample_ready : audio_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_oe         <= 1'b0;
			audio_out_pin0 <= 1'b0;
		end else begin
			sda_oe         <= next_sda_oe;
			audio_out_pin0 <= next_pin0;
		end
	end

	assign sda_out       = 1'b0;
	assign sda_slow_fall = cfg[i2cpc_pkg::BIT_SDA_SLOW];

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence wr_hit_s;
		psel && penable && pwrite && hit;
	endsequence

	// Same new level held two samples: a flip back in between restarts the count
	sequence std_diff2_s;
		(filter_active && !high_speed && (sync2[1] != filt[1])) ##1
		(filter_active && !high_speed && (sync2[1] != filt[1]) && $stable(sync2[1]));
	endsequence

	cfg_reset_zero_a: assert property (!$past(presetn) |-> cfg == 8'h00)
		else $error("config not zero after reset");
	rsvd_read_zero_a: assert property (psel && penable && !pwrite && hit |->
		prdata[4:1] == 4'h0 && prdata[31:8] == 24'h00_0000)
		else $error("reserved bits read nonzero");
	cfg_write_a: assert property (wr_hit_s |=> cfg == ($past(pwdata[7:0]) & 8'he1))
		else $error("config write wrong");
	bypass_pass_a: assert property (bypass |=> filt == $past(sync2))
		else $error("bypass does not pass through");
	std_reject_a: assert property (filter_active && !high_speed && !$past(bypass)
		&& sync2[1] != filt[1] && cnt[1] == 2'b00 |=> filt[1] == $past(filt[1]))
		else $error("short pulse not rejected");
	std_accept_a: assert property (std_diff2_s |=> filt[1] == $past(sync2[1]))
		else $error("standard filter did not follow");
	hs_follow_a: assert property (filter_active && high_speed && sync2[1] != filt[1]
		|=> filt[1] == $past(sync2[1]))
		else $error("high speed filter slow");
	slew_bit_a: assert property (wr_hit_s ##1 1'b1 |-> sda_slow_fall == $past(pwdata[5]))
		else $error("slew control mismatch");
	route_on_a: assert property (cfg[0] |=> audio_out_pin0 == $past(sample_ready))
		else $error("sample ready not routed");
	route_off_a: assert property (!cfg[0] |=> audio_out_pin0 == $past(audio_data))
		else $error("pin not carrying audio data");
	unmapped_err_a: assert property (psel && penable && !hit |-> pslverr && pready)
		else $error("unmapped access not flagged");

endmodule : i2cpc_port_config

/* i2cpc_pkg.sv */
// Constants for the serial port configuration register block.
// Assumes a 25 MHz APB clock and two-wire pins that arrive asynchronously.
package i2cpc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_CFG  = 8'h28;   // Port configuration byte address
	localparam logic [7:0] CFG_RESET = 8'h00;   // Value after reset
	localparam logic [7:0] CFG_WMASK = 8'he1;   // Writable bits 7, 6, 5 and 0

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_BYPASS = 7;
	localparam int BIT_HIGH_SPEED = 6;
	localparam int BIT_SDA_SLOW = 5;
	localparam int BIT_ROUTE = 0;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int FILT_STD_NS = 50;           // Standard, fast and fast-plus rejection
	localparam int FILT_HS_NS = 10;            // High-speed rejection
	localparam int HS_MAX_KHZ = 3400;          // Highest high-speed bus clock
	localparam logic [1:0] FILT_STD_CYC = 2'((FILT_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [1:0] FILT_HS_CYC = 2'((FILT_HS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : i2cpc_pkg

/* i2cpc_host_model.sv */
// Far-side two-wire bus controller driving the SCL and SDA pin levels.
// Assumes pclk at 25 MHz; bus idles high through pull-ups between frames.
`timescale 1ns/1ps

module i2cpc_host_model (
	input  wire logic pclk,
	output logic      scl_in,
	output logic      sda_in
);
	// ****************************************************************
	// Bus activity
	// ****************************************************************
	// Idle level comes from the pull-ups
	initial begin
		scl_in = 1'b1;
		sda_in = 1'b1;
	end

	// Clock runs only inside a frame, 320 ns period, below the high-speed ceiling
	task frame(input int n);
		repeat (n) begin
			scl_in <= 1'b0;
			repeat (4) @(posedge pclk);
			scl_in <= 1'b1;
			repeat (4) @(posedge pclk);
		end
	endtask : frame

	// Low pulse on SDA of n clock cycles, to probe the glitch filter
	task glitch(input int n);
		sda_in <= 1'b0;
		repeat (n) @(posedge pclk);
		sda_in <= 1'b1;
	endtask : glitch
endmodule : i2cpc_host_model

/* tb.sv */
// Self-checking bench for the port configuration register block.
// Assumes the host model on the pins and an APB master in this module.
`timescale 1ns/1ps

module tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, er, scl_in, sda_in, scl_filt, sda_filt, fa;
	logic        tsl = 0, sda_out, sda_oe, slow, srdy = 0, aud = 0, pin0, fa_spi;
	int          mismatches = 0, check_count = 0, cyc = 0, falls = 0, lows = 0;

	// ****************************************************************
	// Clock, pins and design
	// ****************************************************************
	always #20 pclk = ~pclk;
	i2cpc_host_model host_u (.pclk(pclk), .scl_in(scl_in), .sda_in(sda_in));
	i2cpc_port_config dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
		.sda_in(sda_in), .scl_filt(scl_filt), .sda_filt(sda_filt), .filter_active(fa),
		.target_sda_low(tsl), .sda_out(sda_out), .sda_oe(sda_oe), .sda_slow_fall(slow),
		.sample_ready(srdy), .audio_data(aud), .audio_out_pin0(pin0));
	// Four-wire build on the same bus: only its filter state is of interest
	i2cpc_port_config #(.SPI_VARIANT(1'b1)) dut_spi_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(), .pready(), .pslverr(), .scl_in(scl_in), .sda_in(sda_in),
		.scl_filt(), .sda_filt(), .filter_active(fa_spi), .target_sda_low(tsl),
		.sda_out(), .sda_oe(), .sda_slow_fall(), .sample_ready(srdy),
		.audio_data(aud), .audio_out_pin0());

	// Filter outputs watched continuously, since pulses are brief
	always @(posedge pclk) if (sda_filt === 1'b0) lows++;
	always @(negedge scl_filt) falls++;
	// Hang guard, far above the hundred-odd cycles the tests need
	always @(posedge pclk) if (++cyc == 5000) begin
		mismatches++;
		print_verdict();
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %0t: saw %h expected %h", $time, s, e);
		end
	endtask : check

	// One APB transfer; waits on pready, never on a fixed count
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	// Glitch of n cycles, then whether the filtered line dipped
	task gl(input int n, input logic e);
		int base;
		base = lows;
		host_u.glitch(n);
		repeat (8) @(posedge pclk);
		check(lows != base, e);
	endtask : gl

	task print_verdict;
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		int fb;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, i2cpc_pkg::ADDR_CFG, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		check({fa, slow, pin0}, 3'b100);
		check(fa_spi, 1'b0);
		srdy <= 1'b1;
		apb(1'b1, i2cpc_pkg::ADDR_CFG, 32'hffff_ffff);
		apb(1'b0, i2cpc_pkg::ADDR_CFG, 32'h0000_0000);
		check(rd, 32'h0000_00e1);
		check({fa, slow, pin0}, 3'b011);
		gl(1, 1'b1);
		apb(1'b1, i2cpc_pkg::ADDR_CFG, 32'h0000_0000);
		// The pin flop lags the register by one edge
		repeat (2) @(posedge pclk);
		check(pin0, 1'b0);
		{srdy, aud} <= 2'b01;
		repeat (2) @(posedge pclk);
		check(pin0, 1'b1);
		gl(1, 1'b0);
		gl(2, 1'b1);
		fb = falls;
		host_u.frame(1);
		repeat (8) @(posedge pclk);
		check(falls - fb, 1);
		apb(1'b1, i2cpc_pkg::ADDR_CFG, 32'h0000_0040);
		gl(1, 1'b1);
		fb = falls;
		host_u.frame(3);
		repeat (8) @(posedge pclk);
		check(falls - fb, 3);
		// Unmapped accesses are flagged, read zero and leave the register alone
		apb(1'b1, 8'h10, 32'h0000_00ff);
		check(er, 1'b1);
		apb(1'b0, 8'h10, 32'h0000_0000);
		check(er, 1'b1);
		check(rd, 32'h0000_0000);
		apb(1'b0, i2cpc_pkg::ADDR_CFG, 32'h0000_0000);
		check(er, 1'b0);
		check(rd, 32'h0000_0040);
		check(sda_out, 1'b0);
		tsl <= 1'b1;
		repeat (2) @(posedge pclk);
		check(sda_oe, 1'b1);
		// Reset in mid-run, with the register and pins away from their reset state
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check({fa, slow, pin0, sda_oe}, 4'b1000);
		presetn <= 1'b1;
		apb(1'b0, i2cpc_pkg::ADDR_CFG, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		print_verdict();
	end
endmodule : tb
